//--- rtl/idx_pkg.sv
// shared constants for the indexed operand address decoder
// assumes a 12-bit data address space and 16-bit instruction words
package idx_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // register byte addresses on the axi4-lite slave
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FRAME = 8'h04;
    localparam logic [7:0] OFS_BANK = 8'h08;
    localparam logic [7:0] OFS_WREG = 8'h0C;
    localparam logic [7:0] OFS_OPCODE = 8'h10;
    localparam logic [7:0] OFS_MEMIN = 8'h14;
    localparam logic [7:0] OFS_ADDR = 8'h18;
    localparam logic [7:0] OFS_RESULT = 8'h1C;
    // ctrl register fields
    localparam int CTRL_EXT_BIT = 0;
    // result register fields
    localparam int RES_DATA_LSB = 0;
    localparam int RES_WE_BIT = 8;
    localparam int RES_WW_BIT = 9;
    localparam int RES_FLAG_LSB = 16;
    // offset threshold and access bank split
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
    localparam logic [11:0] FRAME_RST = 12'h000;
    localparam logic [7:0] FILL_ONES = 8'hFF;
    // opcode match values on the upper bits
    localparam logic [5:0] OP_ADDW = 6'h09; // 0010 01
    localparam logic [3:0] OP_BITSET = 4'h8; // 1000
    localparam logic [6:0] OP_FILL = 7'h34; // 0110 100
    // flag bit positions: neg, ovf, zero, digit carry, carry
    localparam int FL_C = 0;
    localparam int FL_DC = 1;
    localparam int FL_Z = 2;
    localparam int FL_OV = 3;
    localparam int FL_N = 4;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

//--- rtl/idx_exec.sv
// operand address formation and execution for one decoded instruction
// assumes a registered instruction word, frame pointer and memory byte
`timescale 1ns/1ps
`default_nettype none
module idx_exec
    import idx_pkg::*;
(
    input wire logic ext_en,
    input wire logic [15:0] opcode,
    input wire logic [11:0] frame_ptr,
    input wire logic [3:0] bank_sel,
    input wire logic [7:0] wreg,
    input wire logic [7:0] mem_in,
    input wire logic [4:0] flags_in,
    output logic [11:0] addr,
    output logic [7:0] result,
    output logic mem_we,
    output logic w_we,
    output logic [4:0] flags_out
);
    logic [7:0] f;
    logic acc;
    logic [8:0] sum;
    logic [4:0] lo;
    // address path
    always_comb
    begin
        f = opcode[7:0];
        acc = opcode[8];
        if (acc)
            addr = {bank_sel, f};
        else if (ext_en && f <= IDX_LIMIT)
            addr = 12'(frame_ptr + {4'h0, f});
        else if (f < ACC_SPLIT)
            addr = {4'h0, f};
        else
            addr = {ACC_HIGH_BANK, f};
    end
    // data path for the three indexed forms
    always_comb
    begin
        sum = {1'b0, wreg} + {1'b0, mem_in};
        lo = {1'b0, wreg[3:0]} + {1'b0, mem_in[3:0]};
        result = mem_in;
        mem_we = 1'b0;
        w_we = 1'b0;
        flags_out = flags_in;
        if (opcode[15:10] == OP_ADDW)
        begin
            result = sum[7:0];
            mem_we = opcode[9];
            w_we = ~opcode[9];
            flags_out[FL_C] = sum[8];
            flags_out[FL_DC] = lo[4];
            flags_out[FL_Z] = (sum[7:0] == 8'h00);
            flags_out[FL_N] = sum[7];
            flags_out[FL_OV] = (wreg[7] == mem_in[7]) && (sum[7] != wreg[7]);
        end
        else if (opcode[15:12] == OP_BITSET)
        begin
            result = mem_in | (8'h01 << opcode[11:9]);
            mem_we = 1'b1;
        end
        else if (opcode[15:9] == OP_FILL)
        begin
            result = FILL_ONES;
            mem_we = 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- rtl/idx_decode_top.sv
// axi4-lite wrapper around the indexed operand address decoder
// assumes one clock, synchronous active-high reset, one access at a time
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module idx_decode_top
    import idx_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] aw;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic ext;
        logic [11:0] frame;
        logic [3:0] bank;
        logic [7:0] wreg;
        logic [15:0] op;
        logic [7:0] mem;
        logic [4:0] flags;
        logic [11:0] addr;
        logic [7:0] res;
        logic mwe;
        logic wwe;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [11:0] x_addr;
    logic [7:0] x_res;
    logic x_mwe;
    logic x_wwe;
    logic [4:0] x_flags;

    // execution of the held instruction, combinational in one cycle
    idx_exec u_exec (
        .ext_en(s_q.ext),
        .opcode(s_q.op),
        .frame_ptr(s_q.frame),
        .bank_sel(s_q.bank),
        .wreg(s_q.wreg),
        .mem_in(s_q.mem),
        .flags_in(s_q.flags),
        .addr(x_addr),
        .result(x_res),
        .mem_we(x_mwe),
        .w_we(x_wwe),
        .flags_out(x_flags)
    );

    function automatic logic [31:0] wmerge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // next state: bus handshake, register writes, execution capture
    always_comb
    begin
        logic [31:0] m;
        logic hit;
        m = 32'h0000_0000;
        hit = 1'b0;
        s_d = s_q;
        // one-cycle execution result every clock
        s_d.addr = x_addr;
        s_d.res = x_res;
        s_d.mwe = x_mwe;
        s_d.wwe = x_wwe;
        s_d.awready = 1'b0;
        s_d.wready = 1'b0;
        s_d.arready = 1'b0;
        if (I_AWVALID && !s_q.aw_got && !s_q.awready && !s_q.bvalid)
        begin
            s_d.awready = 1'b1;
            s_d.aw_got = 1'b1;
            s_d.aw = I_AWADDR;
        end
        if (I_WVALID && !s_q.w_got && !s_q.wready && !s_q.bvalid)
        begin
            s_d.wready = 1'b1;
            s_d.w_got = 1'b1;
            s_d.wd = I_WDATA;
            s_d.ws = I_WSTRB;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = AXI_OKAY;
            case (s_q.aw)
                OFS_CTRL:
                begin
                    m = wmerge({31'h0, s_q.ext}, s_q.wd, s_q.ws);
                    s_d.ext = m[CTRL_EXT_BIT];
                end
                OFS_FRAME:
                begin
                    m = wmerge({20'h0, s_q.frame}, s_q.wd, s_q.ws);
                    s_d.frame = m[11:0];
                end
                OFS_BANK:
                begin
                    m = wmerge({28'h0, s_q.bank}, s_q.wd, s_q.ws);
                    s_d.bank = m[3:0];
                end
                OFS_WREG:
                begin
                    m = wmerge({19'h0, s_q.flags, s_q.wreg}, s_q.wd, s_q.ws);
                    s_d.wreg = m[7:0];
                    s_d.flags = m[12:8];
                end
                OFS_OPCODE:
                begin
                    m = wmerge({16'h0, s_q.op}, s_q.wd, s_q.ws);
                    s_d.op = m[15:0];
                end
                OFS_MEMIN:
                begin
                    m = wmerge({24'h0, s_q.mem}, s_q.wd, s_q.ws);
                    s_d.mem = m[7:0];
                end
                default: s_d.bresp = AXI_SLVERR;
            endcase
        end
        else if (s_q.bvalid && I_BREADY)
            s_d.bvalid = 1'b0;
        // commit: the decoded write lands in w or memory image on request
        if (s_q.bvalid && I_BREADY && s_q.aw == OFS_RESULT)
        begin
            if (s_q.wwe)
                s_d.wreg = s_q.res;
            if (s_q.mwe)
                s_d.mem = s_q.res;
            s_d.flags = x_flags;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.aw == OFS_RESULT)
            s_d.bresp = AXI_OKAY;
        // read channel: data are answered the cycle after the address
        // handshake, never alongside ready
        if (I_ARVALID && !s_q.arready && !s_q.rvalid)
        begin
            s_d.arready = 1'b1;
            hit = 1'b1;
            case (I_ARADDR)
                OFS_CTRL: s_d.rdata = {31'h0, s_q.ext};
                OFS_FRAME: s_d.rdata = {20'h0, s_q.frame};
                OFS_BANK: s_d.rdata = {28'h0, s_q.bank};
                OFS_WREG: s_d.rdata = {19'h0, s_q.flags, s_q.wreg};
                OFS_OPCODE: s_d.rdata = {16'h0, s_q.op};
                OFS_MEMIN: s_d.rdata = {24'h0, s_q.mem};
                OFS_ADDR: s_d.rdata = {20'h0, s_q.addr};
                OFS_RESULT: s_d.rdata = {11'h0, x_flags, 6'h00, s_q.wwe,
                    s_q.mwe, s_q.res};
                default:
                begin
                    s_d.rdata = 32'h0000_0000;
                    hit = 1'b0;
                end
            endcase
            s_d.rresp = hit ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_q.arready)
            s_d.rvalid = 1'b1;
        else if (s_q.rvalid && I_RREADY)
            s_d.rvalid = 1'b0;
    end

    // state register
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            s_q <= '0;
            s_q.frame <= FRAME_RST;
        end
        else
            s_q <= s_d;
    end

    assign O_AWREADY = s_q.awready;
    assign O_WREADY = s_q.wready;
    assign O_BVALID = s_q.bvalid;
    assign O_BRESP = s_q.bresp;
    assign O_ARREADY = s_q.arready;
    assign O_RVALID = s_q.rvalid;
    assign O_RRESP = s_q.rresp;
    assign O_RDATA = s_q.rdata;
endmodule
`default_nettype wire

//--- verif/idx_decode_sva.sv
// bus-side checker for the indexed operand address decoder
// bound to idx_decode_top from the bench, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module idx_decode_sva
    import idx_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    input wire logic I_RREADY,
    input wire logic I_BREADY,
    input wire logic O_ARREADY,
    input wire logic O_AWREADY,
    input wire logic O_WREADY,
    input wire logic O_RVALID,
    input wire logic O_BVALID,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic [1:0] O_BRESP
);
    // single clock domain, reset masks every check
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);
    // readies and read data keep the fixed one-cycle timing, bresp follows within one to three cycles
    property p_rd_lat;
        I_ARVALID && !O_ARREADY && !O_RVALID |=> O_ARREADY ##1 O_RVALID;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    property p_aw_pulse;
        O_AWREADY |=> !O_AWREADY;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("aw long");
    property p_w_pulse;
        O_WREADY |=> !O_WREADY;
    endproperty
    a_w_pulse: assert property (p_w_pulse) else $error("w long");
    property p_b_after;
        O_AWREADY && O_WREADY |-> ##[1:3] O_BVALID;
    endproperty
    a_b_after: assert property (p_b_after) else $error("no bresp");
    // answers hold steady while the master stalls
    property p_r_hold;
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata moved");
    property p_b_hold;
        O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp moved");
    // computed address never leaves the twelve-bit space
    property p_addr_w;
        O_ARREADY && I_ARADDR == OFS_ADDR |=> !(|O_RDATA[31:12]);
    endproperty
    a_addr_w: assert property (p_addr_w) else $error("addr wide");
    // reads above the result register are refused with zero data
    property p_unmap;
        O_ARREADY && I_ARADDR > OFS_RESULT
            |=> O_RRESP == AXI_SLVERR && O_RDATA == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the indexed operand address decoder
// drives the axi4-lite slave directly, checker bound below
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import idx_pkg::*;
;
    logic I_MCLK = 1'b0, I_RST = 1'b1, I_BREADY = 1'b0, I_RREADY = 1'b0;
    logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_ARVALID = 1'b0;
    logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h0, O_RDATA, rd;
    logic [1:0] O_BRESP, O_RRESP, rs;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    int fail_count = 0, num_checks = 0, hold = 1;
    idx_decode_top dut (.I_MCLK(I_MCLK), .I_RST(I_RST),
        .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
        .I_WDATA(I_WDATA), .I_WSTRB(4'hF), .I_WVALID(I_WVALID),
        .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
        .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
        .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
        .O_RVALID(O_RVALID), .I_RREADY(I_RREADY));
    // free-running core clock
    always #2 I_MCLK = ~I_MCLK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus transfer; ready raised only after hold edges
    task automatic xfer(input bit w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge I_MCLK);
        I_AWADDR <= a;
        I_ARADDR <= a;
        I_WDATA <= d;
        I_AWVALID <= w;
        I_WVALID <= w;
        I_ARVALID <= !w;
        do
        begin
            @(posedge I_MCLK);
            n++;
            if (O_AWREADY)
                I_AWVALID <= 1'b0;
            if (O_WREADY)
                I_WVALID <= 1'b0;
            if (O_ARREADY)
                I_ARVALID <= 1'b0;
            if (n == hold)
            begin
                I_BREADY <= w;
                I_RREADY <= !w;
            end
        end
        while (!(w ? O_BVALID && I_BREADY : O_RVALID && I_RREADY) && n < 40);
        rd = O_RDATA;
        rs = w ? O_BRESP : O_RRESP;
        I_BREADY <= 1'b0;
        I_RREADY <= 1'b0;
        chk(n < 40, 1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        xfer(0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic setup(input bit e, input logic [11:0] fp,
        input logic [15:0] op);
        xfer(1, OFS_CTRL, {31'h0, e});
        xfer(1, OFS_FRAME, {20'h0, fp});
        xfer(1, OFS_OPCODE, {16'h0, op});
    endtask
    task automatic s_legacy;
        xfer(1, OFS_BANK, 32'h3);
        setup(0, 12'hA00, 16'h0145);
        rc(OFS_ADDR, 32'h345);
        chk(rs, AXI_OKAY);
        setup(0, 12'hA00, 16'h0045);
        rc(OFS_ADDR, 32'h045);
        setup(0, 12'hA00, 16'h0080);
        rc(OFS_ADDR, 32'hF80);
    endtask
    task automatic s_indexed;
        setup(1, 12'hA00, 16'h002C);
        rc(OFS_ADDR, 32'hA2C);
        setup(1, 12'hA00, 16'h005F);
        rc(OFS_ADDR, 32'hA5F);
        setup(1, 12'hA00, 16'h0060);
        rc(OFS_ADDR, 32'hF60);
        setup(1, 12'h000, 16'h0020);
        rc(OFS_ADDR, 32'h020);
        setup(1, 12'hFF0, 16'h0020);
        rc(OFS_ADDR, 32'h010);
        for (int i = 0; i < 16; i++)
        begin
            setup(1, 12'h100, {i[3:0], 12'h010});
            rc(OFS_ADDR, 32'h110);
        end
    endtask
    task automatic s_addw;
        xfer(1, OFS_WREG, 32'h17);
        xfer(1, OFS_MEMIN, 32'h20);
        setup(1, 12'hA00, 16'h262C);
        rc(OFS_RESULT, 32'h137);
        xfer(1, OFS_RESULT, 32'h0);
        chk(rs, AXI_OKAY);
        rc(OFS_MEMIN, 32'h37);
        xfer(1, OFS_WREG, 32'h80);
        xfer(1, OFS_MEMIN, 32'h80);
        setup(1, 12'hA00, 16'h242C);
        rc(OFS_RESULT, 32'h000D0200);
        xfer(1, OFS_RESULT, 32'h0);
        rc(OFS_WREG, 32'h00000D00);
    endtask
    task automatic s_bit_fill;
        xfer(1, OFS_WREG, 32'h1F17);
        xfer(1, OFS_MEMIN, 32'h55);
        setup(1, 12'hA00, 16'h8E0A);
        rc(OFS_RESULT, 32'h001F01D5);
        xfer(1, OFS_RESULT, 32'h0);
        rc(OFS_MEMIN, 32'hD5);
        setup(1, 12'hA00, 16'h682C);
        rc(OFS_RESULT, 32'h001F01FF);
    endtask
    // refused accesses while the master stalls its ready
    task automatic s_refuse;
        hold = 6;
        xfer(1, OFS_ADDR, 32'h5);
        chk(rs, AXI_SLVERR);
        rc(8'h40, 32'h0);
        chk(rs, AXI_SLVERR);
        hold = 1;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // reset, then every scenario in turn
    initial
    begin
        repeat (2) @(posedge I_MCLK);
        I_RST <= 1'b0;
        s_legacy;
        s_indexed;
        s_addw;
        s_bit_fill;
        s_refuse;
        end_of_test;
    end
    // watchdog well beyond the few hundred cycles needed
    initial
    begin
        #200000;
        fail_count++;
        end_of_test;
    end
endmodule
bind idx_decode_top idx_decode_sva u_sva (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .I_RREADY(I_RREADY),
    .I_BREADY(I_BREADY), .O_ARREADY(O_ARREADY), .O_AWREADY(O_AWREADY),
    .O_WREADY(O_WREADY), .O_RVALID(O_RVALID), .O_BVALID(O_BVALID),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_BRESP(O_BRESP));
`default_nettype wire
